// ==== qdu_pkg.sv ====
// Shared constants for the quad converter update control block
package qdu_pkg;
    localparam int FRAME_BITS = 24;
    localparam int CMD_HI = 23;
    localparam int CMD_LO = 20;
    localparam int ADDR_HI = 19;
    localparam int ADDR_LO = 16;
    localparam int DATA_HI = 15;
    localparam int NUM_CH = 4;
    localparam logic [3:0] CMD_WR_INPUT = 4'h1;
    localparam logic [3:0] CMD_UPD_DAC = 4'h2;
    localparam logic [3:0] CMD_WR_UPD = 4'h3;
    localparam logic [3:0] CMD_LD_MASK = 4'h5;
    localparam logic [3:0] CMD_SW_RESET = 4'h6;
    localparam logic [3:0] CMD_REF_SETUP = 4'h7;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam logic REF_RESET = 1'b0;
    localparam logic [15:0] CODE_ZERO = 16'h0000;
    localparam logic [15:0] CODE_MID = 16'h8000;
endpackage

// ==== qdu_ctrl.sv ====
// Update, reset and configuration control of a quad converter
`timescale 1ns/1ps

module qdu_ctrl #(
    parameter int DATA_W = 16
) (
    // System
    input wire logic clk_sys,
    input wire logic nrst,
    // Serial link, own clock domain
    input wire logic link_clk,
    input wire logic link_frame_n,
    input wire logic link_sdi,
    // Asynchronous pins
    input wire logic load_strobe_pin,
    input wire logic reset_pin_n,
    input wire logic reset_level_select,
    // Outputs
    output logic [DATA_W-1:0] dac_code_a,
    output logic [DATA_W-1:0] dac_code_b,
    output logic [DATA_W-1:0] dac_code_c,
    output logic [DATA_W-1:0] dac_code_d,
    output logic [3:0] strobe_mask,
    output logic ref_enable,
    output logic init_done
);
    typedef enum logic [1:0] {
        QDU_WAIT = 2'b01,
        QDU_RUN = 2'b10
    } qdu_state_e;

    // Link side: shift register and frame capture
    logic [qdu_pkg::FRAME_BITS-1:0] shift_q;
    logic [qdu_pkg::FRAME_BITS-1:0] frame_q;
    logic frame_tgl_q;
    logic frame_seen_q;
    logic [1:0] lrst_sync_q;
    logic link_rst_n;

    // System reset brought into the link domain
    always_ff @(posedge link_clk)
    begin
        lrst_sync_q <= {lrst_sync_q[0], nrst};
    end

    assign link_rst_n = lrst_sync_q[1];

    // Data path flops need no reset
    always_ff @(posedge link_clk)
    begin
        if (!link_frame_n)
        begin
            shift_q <= {shift_q[qdu_pkg::FRAME_BITS-2:0], link_sdi};
        end
    end

    // Rising frame edge seen as the first idle clock after a frame
    always_ff @(posedge link_clk)
    begin
        if (!link_rst_n)
        begin
            frame_seen_q <= 1'b0;
            frame_tgl_q <= 1'b0;
        end
        else
        begin
            frame_seen_q <= !link_frame_n;
            if (link_frame_n && frame_seen_q)
            begin
                frame_q <= shift_q;
                frame_tgl_q <= !frame_tgl_q;
            end
        end
    end

    // Toggle crossing into the system domain
    logic [2:0] tgl_sync_q;
    logic frame_evt;
    logic [qdu_pkg::FRAME_BITS-1:0] cmd_word_q;

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            tgl_sync_q <= 3'h0;
        end
        else
        begin
            tgl_sync_q <= {tgl_sync_q[1:0], frame_tgl_q};
        end
    end

    assign frame_evt = tgl_sync_q[2] ^ tgl_sync_q[1];

    always_ff @(posedge clk_sys)
    begin
        if (frame_evt)
        begin
            cmd_word_q <= frame_q;
        end
    end

    // Pin synchronisers
    logic [1:0] strobe_sync_q;
    logic [1:0] rst_sync_q;
    logic [1:0] sel_sync_q;
    logic strobe_prev_q;
    logic strobe_fall;

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            strobe_sync_q <= 2'h3;
            rst_sync_q <= 2'h0;
            sel_sync_q <= 2'h0;
            strobe_prev_q <= 1'b1;
        end
        else
        begin
            strobe_sync_q <= {strobe_sync_q[0], load_strobe_pin};
            rst_sync_q <= {rst_sync_q[0], reset_pin_n};
            sel_sync_q <= {sel_sync_q[0], reset_level_select};
            strobe_prev_q <= strobe_sync_q[1];
        end
    end

    assign strobe_fall = strobe_prev_q && !strobe_sync_q[1];

    // Decode of the delayed command word
    logic cmd_valid_q;
    logic [3:0] cmd_code;
    logic [3:0] cmd_addr;
    logic [DATA_W-1:0] cmd_data;

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            cmd_valid_q <= 1'b0;
        end
        else
        begin
            cmd_valid_q <= frame_evt;
        end
    end

    assign cmd_code = cmd_word_q[qdu_pkg::CMD_HI:qdu_pkg::CMD_LO];
    assign cmd_addr = cmd_word_q[qdu_pkg::ADDR_HI:qdu_pkg::ADDR_LO];
    assign cmd_data = cmd_word_q[qdu_pkg::DATA_HI -: DATA_W];

    function automatic logic is_cmd(input logic [3:0] code, input logic [3:0] want);
        is_cmd = (code == want);
    endfunction

    // Command strobes
    logic do_wr_in;
    logic do_upd;
    logic do_wr_upd;
    logic do_sw_rst;
    logic do_mask;
    logic do_ref;

    assign do_wr_in = cmd_valid_q && is_cmd(cmd_code, qdu_pkg::CMD_WR_INPUT);
    assign do_upd = cmd_valid_q && is_cmd(cmd_code, qdu_pkg::CMD_UPD_DAC);
    assign do_wr_upd = cmd_valid_q && is_cmd(cmd_code, qdu_pkg::CMD_WR_UPD);
    assign do_sw_rst = cmd_valid_q && is_cmd(cmd_code, qdu_pkg::CMD_SW_RESET);
    assign do_mask = cmd_valid_q && is_cmd(cmd_code, qdu_pkg::CMD_LD_MASK);
    assign do_ref = cmd_valid_q && is_cmd(cmd_code, qdu_pkg::CMD_REF_SETUP);

    // Power-on sequencing
    qdu_state_e state_q;
    logic running;

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            state_q <= QDU_WAIT;
        end
        else
        begin
            case (state_q)
                QDU_WAIT:
                begin
                    if (rst_sync_q[1])
                    begin
                        state_q <= QDU_RUN;
                    end
                end
                QDU_RUN:
                begin
                    state_q <= QDU_RUN;
                end
                default:
                begin
                    state_q <= QDU_WAIT;
                end
            endcase
        end
    end

    assign running = (state_q == QDU_RUN);
    assign init_done = running;

    // Configuration registers
    logic [3:0] mask_q;
    logic ref_off_q;

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            mask_q <= qdu_pkg::MASK_RESET;
            ref_off_q <= qdu_pkg::REF_RESET;
        end
        else if (cmd_valid_q && running)
        begin
            if (is_cmd(cmd_code, qdu_pkg::CMD_LD_MASK))
            begin
                mask_q <= cmd_word_q[3:0];
            end
            if (is_cmd(cmd_code, qdu_pkg::CMD_REF_SETUP))
            begin
                ref_off_q <= cmd_word_q[0];
            end
        end
    end

    assign strobe_mask = mask_q;
    assign ref_enable = !ref_off_q;

    // Input and DAC registers per channel
    logic [DATA_W-1:0] in_q [qdu_pkg::NUM_CH];
    logic [DATA_W-1:0] dac_q [qdu_pkg::NUM_CH];
    logic [DATA_W-1:0] clear_code;
    logic upd_block;

    assign clear_code = sel_sync_q[1] ? qdu_pkg::CODE_MID[15 -: DATA_W]
                                      : qdu_pkg::CODE_ZERO[15 -: DATA_W];
    assign upd_block = !rst_sync_q[1] || !running;

    // Channels that take the strobe edge; masked ones ignore the edge, but a write input with the strobe low still loads their DAC
    logic [qdu_pkg::NUM_CH-1:0] strobe_ld;

    always_comb
    begin
        for (int i = 0; i < qdu_pkg::NUM_CH; i++)
        begin
            strobe_ld[i] = strobe_fall && !mask_q[i] && !upd_block;
        end
    end

    // Input registers
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < qdu_pkg::NUM_CH; i++)
            begin
                in_q[i] <= '0;
            end
        end
        else if (!running)
        begin
            for (int i = 0; i < qdu_pkg::NUM_CH; i++)
            begin
                in_q[i] <= clear_code;
            end
        end
        else if (!rst_sync_q[1])
        begin
            for (int i = 0; i < qdu_pkg::NUM_CH; i++)
            begin
                in_q[i] <= clear_code;
            end
        end
        else
        begin
            for (int i = 0; i < qdu_pkg::NUM_CH; i++)
            begin
                if (do_sw_rst)
                begin
                    in_q[i] <= clear_code;
                end
                else if ((do_wr_in || do_wr_upd) && cmd_addr[i])
                begin
                    in_q[i] <= cmd_data;
                end
                else if (do_mask || do_ref)
                begin
                    in_q[i] <= in_q[i];
                end
            end
        end
    end

    // DAC registers; a software reset, or a write or update command to the channel, beats a strobe edge in the same cycle
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < qdu_pkg::NUM_CH; i++)
            begin
                dac_q[i] <= '0;
            end
        end
        else if (!running)
        begin
            for (int i = 0; i < qdu_pkg::NUM_CH; i++)
            begin
                dac_q[i] <= clear_code;
            end
        end
        else if (!rst_sync_q[1])
        begin
            for (int i = 0; i < qdu_pkg::NUM_CH; i++)
            begin
                dac_q[i] <= clear_code;
            end
        end
        else
        begin
            for (int i = 0; i < qdu_pkg::NUM_CH; i++)
            begin
                if (do_sw_rst)
                begin
                    dac_q[i] <= clear_code;
                end
                else if (do_wr_upd && cmd_addr[i])
                begin
                    dac_q[i] <= cmd_data;
                end
                else if (do_wr_in && cmd_addr[i] && !strobe_sync_q[1])
                begin
                    dac_q[i] <= cmd_data;
                end
                else if (do_upd && cmd_addr[i])
                begin
                    dac_q[i] <= in_q[i];
                end
                else if (strobe_ld[i])
                begin
                    dac_q[i] <= in_q[i];
                end
            end
        end
    end

    assign dac_code_a = dac_q[0];
    assign dac_code_b = dac_q[1];
    assign dac_code_c = dac_q[2];
    assign dac_code_d = dac_q[3];
endmodule // qdu_ctrl

// ==== qdu_ctrl_assertions.sv ====
// Checker for the quad converter update control block
`timescale 1ns/1ps
module qdu_ctrl_chk #(
    parameter int DATA_W = 16
) (
    // Clock, reset and pins
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic link_frame_n,
    input wire logic reset_pin_n,
    input wire logic reset_level_select,
    // Outputs watched
    input wire logic [DATA_W-1:0] dac_code_a,
    input wire logic [DATA_W-1:0] dac_code_d,
    input wire logic [3:0] strobe_mask,
    input wire logic ref_enable,
    input wire logic init_done
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    wire logic quiet_a = strobe_mask[0] && link_frame_n && reset_pin_n;
    a_mask_reset: assert property ($rose(nrst) |-> strobe_mask == 4'h0)
        else $error("mask not clear after reset");
    a_ref_reset: assert property ($rose(nrst) |-> ref_enable)
        else $error("reference off after reset");
    a_clear_zero: assert property ((!reset_pin_n && !reset_level_select)[*6]
        |-> dac_code_a == 16'h0000) else $error("zero clear missing");
    a_clear_mid: assert property ((!reset_pin_n && reset_level_select)[*6]
        |-> dac_code_d == 16'h8000) else $error("midscale clear missing");
    a_init_wait: assert property ($rose(init_done) |-> $past(reset_pin_n, 2))
        else $error("init while reset pin low");
    a_power_level: assert property ((!init_done && !reset_level_select)[*4]
        |-> dac_code_a == 16'h0000) else $error("power-up level wrong");
    a_masked_hold: assert property (quiet_a[*8] ##1 quiet_a[*3]
        |-> $stable(dac_code_a)) else $error("masked channel moved");
    a_cfg_quiet: assert property (link_frame_n[*8] ##1 link_frame_n[*3]
        |-> $stable(strobe_mask) && $stable(ref_enable)) else $error("config moved");
endmodule // qdu_ctrl_chk

// ==== qdu_host_model.sv ====
// Serial host model that frames command words
`timescale 1ns/1ps
module qdu_host_model (
    // Link
    output logic link_clk,
    output logic link_frame_n,
    output logic link_sdi
);
    initial
    begin
        link_clk = 1'b0;
        link_frame_n = 1'b1;
        link_sdi = 1'b0;
        repeat (4) edge_once();
    end
    task automatic edge_once();
        #32 link_clk = 1'b1;
        #32 link_clk = 1'b0;
    endtask
    // Clock stands still outside frames, apart from four edges at start and one idle edge after each frame
    task automatic send(input logic [23:0] w);
        link_frame_n = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            link_sdi = w[i];
            edge_once();
        end
        link_frame_n = 1'b1;
        link_sdi = ~w[0];
        edge_once();
    endtask
endmodule // qdu_host_model

// ==== qdu_ctrl_tb_top.sv ====
// Testbench for the quad converter update control block
`timescale 1ns/1ps
module qdu_ctrl_tb_top;
    logic clk_sys, nrst, stb, rpin, rsel;
    wire logic lclk, lfn, lsdi, ref_en, init_d;
    wire logic [15:0] dc [4];
    wire logic [3:0] msk;
    int n_errors, samples_checked, inr[4], dac[4], mask, refb;
    qdu_host_model HOST (.link_clk(lclk), .link_frame_n(lfn), .link_sdi(lsdi));
    qdu_ctrl DUT (.clk_sys(clk_sys), .nrst(nrst), .link_clk(lclk), .link_frame_n(lfn),
        .link_sdi(lsdi), .load_strobe_pin(stb), .reset_pin_n(rpin),
        .reset_level_select(rsel), .dac_code_a(dc[0]), .dac_code_b(dc[1]),
        .dac_code_c(dc[2]), .dac_code_d(dc[3]), .strobe_mask(msk),
        .ref_enable(ref_en), .init_done(init_d));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string nm);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cmp_all();
        for (int i = 0; i < 4; i++)
            chk(dc[i], 16'(dac[i]), "dac_code");
        chk({12'h000, msk}, 16'(mask), "strobe_mask");
        chk({15'h0000, ref_en}, 16'(!refb), "ref_enable");
    endtask
    task automatic clr_all();
        for (int i = 0; i < 4; i++)
        begin
            inr[i] = rsel ? 32'h00008000 : 32'h00000000;
            dac[i] = inr[i];
        end
    endtask
    task automatic frame(input logic [3:0] c, input int a, input logic [15:0] d);
        HOST.send({c, (c == 4'h5) ? 4'($urandom) : 4'(1 << a), d});
        repeat (12) @(negedge clk_sys);
        if (rpin && (c == 4'h1 || c == 4'h3))
            inr[a] = d;
        if (rpin && (c == 4'h3 || (c == 4'h1 && !stb)))
            dac[a] = d;
        if (rpin && c == 4'h2)
            dac[a] = inr[a];
        if (c == 4'h5)
            mask = d[3:0];
        if (c == 4'h7)
            refb = d[0];
        if (rpin && c == 4'h6)
            clr_all();
        cmp_all();
    endtask
    task automatic set_stb(input logic v);
        @(negedge clk_sys);
        if (stb && !v)
            for (int i = 0; i < 4; i++)
                if (!mask[i])
                    dac[i] = inr[i];
        stb = v;
        repeat (8) @(negedge clk_sys);
        cmp_all();
    endtask
    task automatic results();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial
    begin
        #400000;
        n_errors++;
        results();
    end
    initial
    begin
        nrst = 1'b0;
        stb = 1'b1;
        rpin = 1'b0;
        rsel = 1'b0;
        clr_all();
        void'($urandom(13569));
        repeat (6) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (10) @(negedge clk_sys);
        chk({15'h0000, init_d}, 16'h0000, "init_done");
        rpin = 1'b1;
        repeat (8) @(negedge clk_sys);
        chk({15'h0000, init_d}, 16'h0001, "init_done");
        cmp_all();
        $display("test 1 done");
        frame(4'h5, 0, {12'($urandom), 4'($urandom_range(7)) | 4'h1});
        for (int i = 0; i < 4; i++)
            frame(4'h1, i, 16'($urandom));
        set_stb(1'b0);
        set_stb(1'b1);
        $display("test 2 done");
        for (int k = 0; k < 24; k++)
        begin
            if (k == 12)
                set_stb(1'b0);
            frame(4'(1 + $urandom_range(2)), $urandom_range(3), 16'($urandom));
        end
        set_stb(1'b1);
        $display("test 3 done");
        frame(4'h7, 2, 16'hFFFF);
        frame(4'h7, 1, 16'hFFFE);
        $display("test 4 done");
        @(negedge clk_sys);
        rsel = 1'b1;
        rpin = 1'b0;
        repeat (8) @(negedge clk_sys);
        clr_all();
        cmp_all();
        frame(4'h3, 1, 16'($urandom));
        rpin = 1'b1;
        repeat (8) @(negedge clk_sys);
        cmp_all();
        $display("test 5 done");
        frame(4'h3, 2, 16'($urandom));
        rsel = 1'b0;
        frame(4'h6, 0, 16'($urandom));
        $display("test 6 done");
        results();
    end
endmodule // qdu_ctrl_tb_top
bind qdu_ctrl qdu_ctrl_chk #(.DATA_W(DATA_W)) CHK (.clk_sys(clk_sys), .nrst(nrst),
    .link_frame_n(link_frame_n), .reset_pin_n(reset_pin_n),
    .reset_level_select(reset_level_select), .dac_code_a(dac_code_a),
    .dac_code_d(dac_code_d), .strobe_mask(strobe_mask), .ref_enable(ref_enable),
    .init_done(init_done));
